// ===== efm_mac_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "efm_defines.svh"
module efm_mac_top
  import efm_pkg::*;
#(
  parameter int NIB_DIV    = `EFM_NIB_PERIOD_NS / `EFM_CLK_PERIOD_NS,
  parameter int AW         = 9,
  parameter int MAX_FRAMES = 31
) (
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic      [3:0]  phy_tx_nib_o,
  output logic             phy_tx_en_o,
  input  wire logic        phy_rx_clk_i,
  input  wire logic        phy_rx_dv_i,
  input  wire logic [3:0]  phy_rx_nib_i
);
  localparam int DEPTH = 2**AW;

  if (NIB_DIV < 2 || NIB_DIV > 255 || AW < 5 || AW > 14 ||
      MAX_FRAMES < 1 || MAX_FRAMES > 63) begin : g_bad_param
    $error("efm_mac_top: parameter out of range");
  end

  efm_tx_ctl_t   transmit_control;
  efm_tx_state_t tstate;
  efm_tx_state_t t_next;
  efm_rx_state_t rstate;
  efm_phy_rx_t   rxs1;
  efm_phy_rx_t   rxs2;
  logic          rx_clk3;
  logic [7:0]    div_cnt;
  logic          nib_tick;
  logic          rx_on;
  logic          rej_bad;
  logic [3:0]    events;
  logic [3:0]    ev_set;
  logic [31:0]   rd_mux;
  logic          tx_go;
  logic [AW:0]   txw;
  logic [31:0]   tx_word;
  logic [31:0]   tx_crc;
  logic [11:0]   tcnt;
  logic [11:0]   t_ncnt;
  logic [AW+1:0] tbyte;
  logic          tph;
  logic [10:0]   tlen;
  logic          t_last;
  logic [7:0]    t_oct;
  logic [31:0]   rx_word;
  logic [31:0]   rx_crc;
  logic [31:0]   rasm;
  logic [15:0]   rhead;
  logic [3:0]    rlo;
  logic          rph;
  logic [1:0]    rlane;
  logic [AW:0]   rwi;
  logic [11:0]   flen;
  logic [15:0]   rlt;
  logic          rgrp;
  logic [AW:0]   rcommit;
  logic [AW:0]   rrd;
  logic [5:0]    rcount;
  logic [12:0]   rrem;
  logic [15:0]   last_lt;
  logic          last_type;
  logic          last_group;
  logic          rwe;
  logic [AW-1:0] rwaddr;
  logic [31:0]   rwdata;

  // --------------------------------------------------------------------
  // nibble rate enable and receive pin synchroniser
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      div_cnt  <= 8'h00;
      nib_tick <= 1'b0;
    end else begin
      nib_tick <= (div_cnt == 8'(NIB_DIV - 1));
      div_cnt  <= (div_cnt == 8'(NIB_DIV - 1)) ? 8'h00 : div_cnt + 8'h01;
    end
  end

  // two flops on every phy input, a third on the clock for its edge
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rxs1    <= '0;
      rxs2    <= '0;
      rx_clk3 <= 1'b0;
    end else begin
      rxs1    <= {phy_rx_clk_i, phy_rx_dv_i, phy_rx_nib_i};
      rxs2    <= rxs1;
      rx_clk3 <= rxs2.clk;
    end
  end
  wire rx_stb = rxs2.clk & ~rx_clk3;

  // --------------------------------------------------------------------
  // avalon slave decode
  // --------------------------------------------------------------------
  wire [2:0] reg_idx  = avs_address_i[4:2];
  wire       acc      = (avs_read_i | avs_write_i) & avs_waitrequest_o;
  wire       wr_acc   = avs_write_i & acc & avs_byteenable_i[0];
  wire       rd_acc   = avs_read_i & acc;
  wire       wr_transmit_control  = wr_acc & (reg_idx == `EFM_REG_TRANSMIT_CONTROL);
  wire       wr_rctl  = wr_acc & (reg_idx == `EFM_REG_RCTL);
  wire       wr_evt   = wr_acc & (reg_idx == `EFM_REG_EVT);
  wire       wr_go    = wr_acc & (reg_idx == `EFM_REG_TXGO);
  wire       rx_empty = (rrd == rcommit);
  wire       rx_pop   = rd_acc & (reg_idx == `EFM_REG_RXDATA) & ~rx_empty;
  wire       flush    = wr_rctl & avs_writedata_i[`EFM_RCTL_FLUSH];
  // one frame only: pushes stop while sending or when full
  wire       tx_push  = wr_acc & (reg_idx == `EFM_REG_TXDATA) &
                        (tstate == TX_IDLE) & ~tx_go & ~txw[AW];

  // read data selection
  always_comb begin
    case (reg_idx)
      `EFM_REG_TRANSMIT_CONTROL:   rd_mux = {28'h000_0000, transmit_control};
      `EFM_REG_RCTL:   rd_mux = {30'h0000_0000, rej_bad, rx_on};
      `EFM_REG_EVT:    rd_mux = {28'h000_0000, events};
      `EFM_REG_RXDATA: rd_mux = rx_empty ? 32'h0000_0000 : rx_word;
      `EFM_REG_TXGO:   rd_mux = {16'h0000, tx_go, 15'(txw)};
      `EFM_REG_RXSTAT: rd_mux = {last_lt, 6'h00, last_type, last_group,
                                 2'h0, rcount};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // answer one cycle after the request is seen
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end else begin
      avs_waitrequest_o <= ~acc;
      if (rd_acc)
        avs_readdata_o <= rd_mux;
    end
  end

  // control registers and sticky events, set beats clear
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      transmit_control    <= `EFM_TRANSMIT_CONTROL_RST;
      rx_on   <= 1'b0;
      rej_bad <= `EFM_REJ_RST;
      events  <= 4'h0;
    end else begin
      if (wr_transmit_control)
        transmit_control <= avs_writedata_i[3:0];
      if (wr_rctl) begin
        rx_on   <= avs_writedata_i[`EFM_RCTL_ON];
        rej_bad <= avs_writedata_i[`EFM_RCTL_REJ];
      end
      events <= (events & ~(wr_evt ? avs_writedata_i[3:0] : 4'h0)) | ev_set;
    end
  end

  // --------------------------------------------------------------------
  // transmit path
  // --------------------------------------------------------------------
  wire tx_start = nib_tick & (tstate == TX_IDLE) & tx_go & transmit_control.tx_on &
                  (transmit_control.duplex | (rstate == RX_IDLE));
  wire tx_done  = nib_tick & (tstate == TX_FCS) & tph & t_last;
  wire t_fill   = transmit_control.fill & (tlen < `EFM_MIN_DATA);
  wire t_ram    = (tstate == TX_BODY) | ((tstate == TX_FCS) & ~transmit_control.crc_on);
  wire [7:0] tx_lane = tx_word[{tbyte[1:0], 3'b000} +: 8];
  wire [7:0] crc_oct = ~tx_crc[{tcnt[1:0], 3'b000} +: 8];
  wire       tx_cov  = (tstate == TX_BODY) | (tstate == TX_PAD);

  // octet on the line and the step after it
  always_comb begin
    t_oct  = 8'h00;
    t_next = tstate;
    t_ncnt = 12'h000;
    t_last = 1'b0;
    case (tstate)
      TX_PRE: begin
        t_oct  = (tcnt == `EFM_PRE_LAST) ? `EFM_SFD_OCT
                                          : `EFM_PRE_OCT;
        t_last = (tcnt == `EFM_PRE_LAST);
        t_next = TX_BODY;
      end
      TX_BODY: begin
        t_oct  = tx_lane;
        t_last = (tcnt == 12'(tlen) + `EFM_HDR_LAST);
        t_next = t_fill ? TX_PAD : TX_FCS;
        t_ncnt = t_fill ? 12'(tlen) : 12'h000;
      end
      TX_PAD: begin
        t_last = (tcnt == `EFM_PAD_LAST);
        t_next = TX_FCS;
      end
      TX_FCS: begin
        t_oct  = transmit_control.crc_on ? crc_oct : tx_lane;
        t_last = (tcnt == `EFM_FCS_LAST);
        t_next = TX_IDLE;
      end
      default: t_oct = 8'h00;
    endcase
  end

  // one nibble per tick, low nibble first
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tstate       <= TX_IDLE;
      tcnt         <= 12'h000;
      tbyte        <= '0;
      tph          <= 1'b0;
      tlen         <= 11'h000;
      phy_tx_nib_o <= 4'h0;
      phy_tx_en_o  <= 1'b0;
    end else if (nib_tick) begin
      if (tstate == TX_IDLE) begin
        phy_tx_en_o <= 1'b0;
        tph         <= 1'b0;
        tcnt        <= 12'h000;
        tbyte       <= '0;
        if (tx_start) begin
          tstate <= TX_PRE;
          tlen   <= tx_word[10:0];
          tbyte  <= (AW+2)'(2);
        end
      end else begin
        phy_tx_en_o  <= 1'b1;
        phy_tx_nib_o <= tph ? t_oct[7:4] : t_oct[3:0];
        tph          <= ~tph;
        if (tph) begin
          tcnt <= tcnt + 12'h001;
          if (t_ram)
            tbyte <= tbyte + (AW+2)'(1);
          if (t_last) begin
            tcnt   <= t_ncnt;
            tstate <= t_next;
          end
        end
      end
    end
  end

  // fifo fill pointer and send request
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      txw   <= '0;
      tx_go <= 1'b0;
    end else if (tx_done) begin
      txw   <= '0;
      tx_go <= 1'b0;
    end else begin
      if (tx_push)
        txw <= txw + (AW+1)'(1);
      if (wr_go && avs_writedata_i[0])
        tx_go <= 1'b1;
    end
  end

  efm_ram #(.AW(AW)) u_tx_ram (
    .core_clk_i (core_clk_i),
    .we_i       (tx_push),
    .waddr_i    (txw[AW-1:0]),
    .wdata_i    (avs_writedata_i),
    .raddr_i    (tbyte[AW+1:2]),
    .rdata_o    (tx_word)
  );

  // checksum over header, data and pad
  efm_crc_nib u_tx_crc (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .init_i     (tx_start),
    .en_i       (nib_tick & tx_cov),
    .nib_i      (tph ? t_oct[7:4] : t_oct[3:0]),
    .crc_o      (tx_crc)
  );

  // --------------------------------------------------------------------
  // receive path
  // --------------------------------------------------------------------
  wire [AW:0] used     = rcommit - rrd;
  wire [AW:0] free_w   = (AW+1)'(DEPTH) - used;
  wire        nofit    = (rwi >= free_w);
  wire        rx_begin = (rstate == RX_IDLE) & rx_stb & rxs2.dv;
  wire        rx_take  = rx_begin & rx_on & ~tx_start &
                         (transmit_control.duplex | (tstate == TX_IDLE));
  wire        cnt_full = (rcount >= 6'(MAX_FRAMES));
  wire        byte_done = (rstate == RX_DATA) & rx_stb & rxs2.dv & rph;
  wire [7:0]  rbyte    = {rxs2.nib, rlo};
  wire        word_done = byte_done & (rlane == 2'h3);
  wire        ovf_data = word_done & (rwi != '0) & nofit;
  wire        crc_bad  = (rx_crc != `EFM_CRC_RESID);
  wire        keep     = ~(crc_bad & rej_bad);
  wire        tail_ovf = (rstate == RX_TAIL) & keep & (rlane != 2'h0) &
                         nofit;
  wire        head     = (rstate == RX_HEAD);
  wire        ovf_ev   = (rx_take & cnt_full) | ovf_data | tail_ovf;
  wire [12:0] hdr_words = (13'(rx_word[11:0]) + 13'h0005) >> 2;
  wire [7:0]  sfd_oct   = `EFM_SFD_OCT; // named so its high nibble can be picked

  // ram write port: full words, the tail word, then the head word
  assign rwe    = (word_done & (rwi != '0) & ~nofit) | head |
                  ((rstate == RX_TAIL) & keep & (rlane != 2'h0) &
                   (rwi != '0) & ~nofit);
  assign rwaddr = rcommit[AW-1:0] + (head ? '0 : rwi[AW-1:0]);
  assign rwdata = head ? {rhead, 4'h0, flen} :
                  word_done ? {rbyte, rasm[23:0]} : rasm;

  // events raised by both paths
  assign ev_set[`EFM_EV_OVF]  = ovf_ev;
  assign ev_set[`EFM_EV_RXOK] = head;
  assign ev_set[`EFM_EV_TXOK] = tx_done;
  assign ev_set[`EFM_EV_CRC]  = (rstate == RX_TAIL) & crc_bad;

  // frame reception state
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rstate  <= RX_IDLE;
      rasm    <= 32'h0000_0000;
      rhead   <= 16'h0000;
      rlo     <= 4'h0;
      rph     <= 1'b0;
      rlane   <= 2'h2;
      rwi     <= '0;
      flen    <= 12'h000;
      rlt     <= 16'h0000;
      rgrp    <= 1'b0;
      rcommit <= '0;
    end else begin
      case (rstate)
        RX_IDLE: begin
          if (rx_begin)
            rstate <= (rx_take && !cnt_full) ? RX_SFD : RX_DROP;
        end
        RX_SFD: begin
          rph   <= 1'b0;
          rlane <= 2'h2; // data starts after the two length bytes
          rwi   <= '0;
          flen  <= 12'h000;
          rasm  <= 32'h0000_0000;
          // the phy clock may stop once valid drops, so end on the level
          if (!rxs2.dv)
            rstate <= RX_IDLE;
          else if (rx_stb && rxs2.nib == sfd_oct[7:4])
            rstate <= RX_DATA;
        end
        RX_DATA: begin
          if (!rxs2.dv)
            rstate <= RX_TAIL;
          else if (rx_stb) begin
            rph <= ~rph;
            if (!rph)
              rlo <= rxs2.nib;
          end
          if (byte_done) begin
            flen <= flen + 12'h001;
            rlane <= rlane + 2'h1;
            rasm[{rlane, 3'b000} +: 8] <= rbyte;
            if (flen == 12'h000)
              rgrp <= rbyte[0];
            if (flen == 12'h00c)
              rlt[15:8] <= rbyte;
            if (flen == 12'h00d)
              rlt[7:0] <= rbyte;
            if (word_done) begin
              rasm <= 32'h0000_0000;
              rwi  <= rwi + (AW+1)'(1);
              if (rwi == '0)
                rhead <= {rbyte, rasm[23:16]};
              if (ovf_data)
                rstate <= RX_DROP;
            end
          end
        end
        RX_TAIL: begin
          if (rwi == '0)
            rhead <= rasm[31:16];
          rstate <= (keep && !tail_ovf) ? RX_HEAD : RX_IDLE;
        end
        RX_HEAD: begin
          // next frame begins on a fresh word
          rcommit <= rcommit + rwi +
                     (AW+1)'(rlane != 2'h0);
          rstate  <= RX_IDLE;
        end
        RX_DROP: begin
          if (!rxs2.dv)
            rstate <= RX_IDLE;
        end
        default: rstate <= RX_IDLE;
      endcase
    end
  end

  // what software sees of the last stored frame
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      last_lt    <= 16'h0000;
      last_type  <= 1'b0;
      last_group <= 1'b0;
    end else if (head) begin
      last_lt    <= rlt;
      last_type  <= (rlt > `EFM_MAX_LEN);
      last_group <= rgrp;
    end
  end

  // read pointer, frame count and flush
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rrd    <= '0;
      rcount <= 6'h00;
      rrem   <= 13'h0000;
    end else if (flush) begin
      rrd    <= rcommit;
      rcount <= 6'h00;
      rrem   <= 13'h0000;
    end else begin
      if (rx_pop) begin
        rrd  <= rrd + (AW+1)'(1);
        rrem <= (rrem == 13'h0000) ? hdr_words - 13'h0001
                                   : rrem - 13'h0001;
      end
      rcount <= rcount + 6'(head) -
                6'(rx_pop && rrem == 13'h0000);
    end
  end

  efm_ram #(.AW(AW)) u_rx_ram (
    .core_clk_i (core_clk_i),
    .we_i       (rwe),
    .waddr_i    (rwaddr),
    .wdata_i    (rwdata),
    .raddr_i    (rrd[AW-1:0]),
    .rdata_o    (rx_word)
  );

  efm_crc_nib u_rx_crc (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .init_i     (rstate == RX_SFD),
    .en_i       ((rstate == RX_DATA) & rx_stb & rxs2.dv),
    .nib_i      (rxs2.nib),
    .crc_o      (rx_crc)
  );

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_pre_end;
    nib_tick && tstate == TX_PRE && tph && tcnt == `EFM_PRE_LAST;
  endsequence
  sequence s_body_open;
    tstate == TX_BODY && tcnt == 12'h000 && !tph;
  endsequence

  a_pre_pattern: assert property (nib_tick && tstate == TX_PRE &&
      tcnt < `EFM_PRE_LAST |=> phy_tx_nib_o == 4'h5)
    else $error("preamble nibble wrong");
  a_sfd_then_body: assert property (s_pre_end |=>
      phy_tx_nib_o == 4'hd ##0 s_body_open)
    else $error("delimiter or body start wrong");
  a_low_nib_first: assert property (nib_tick && tstate != TX_IDLE &&
      !tph |=> phy_tx_nib_o == $past(t_oct[3:0]) && tph)
    else $error("nibble order wrong");
  a_pad_only_short: assert property ($rose(tstate == TX_PAD) |->
      transmit_control.fill && tlen < `EFM_MIN_DATA)
    else $error("pad without fill or long payload");
  a_fcs_insert: assert property (nib_tick && tstate == TX_FCS &&
      transmit_control.crc_on && tph |=> phy_tx_nib_o == $past(crc_oct[7:4]))
    else $error("appended checksum wrong");
  a_half_duplex: assert property (!transmit_control.duplex |->
      !(tstate != TX_IDLE && rstate inside {RX_SFD, RX_DATA}))
    else $error("both directions active in half duplex");
  a_bad_dropped: assert property (rstate == RX_TAIL && crc_bad &&
      rej_bad |=> rstate == RX_IDLE && $stable(rcommit))
    else $error("bad frame kept");
  a_frame_cap: assert property (rcount <= 6'(MAX_FRAMES))
    else $error("too many frames held");
  a_ovf_flag: assert property (ovf_ev |=>
      events[`EFM_EV_OVF] ##1 rstate inside {RX_DROP, RX_IDLE})
    else $error("overflow not flagged");
  a_word_align: assert property (head |=>
      rcommit == $past(rcommit) + $past(rwi) +
      (AW+1)'($past(rlane) != 2'h0))
    else $error("frame start not word aligned");
endmodule : efm_mac_top
`default_nettype wire

// ===== efm_defines.svh
`ifndef EFM_DEFINES_SVH
`define EFM_DEFINES_SVH
// --------------------------------------------------------------------
// register word indices (byte address = index * 4)
// --------------------------------------------------------------------
`define EFM_REG_TRANSMIT_CONTROL   3'h0
`define EFM_REG_RCTL   3'h1
`define EFM_REG_EVT    3'h2
`define EFM_REG_TXDATA 3'h3
`define EFM_REG_RXDATA 3'h4
`define EFM_REG_TXGO   3'h5
`define EFM_REG_RXSTAT 3'h6
// rx control bits
`define EFM_RCTL_ON    0
`define EFM_RCTL_REJ   1
`define EFM_RCTL_FLUSH 2
// raw event status bits
`define EFM_EV_OVF     0
`define EFM_EV_RXOK    1
`define EFM_EV_TXOK    2
`define EFM_EV_CRC     3
// reset values
`define EFM_TRANSMIT_CONTROL_RST   4'h0
`define EFM_REJ_RST    1'b1
// --------------------------------------------------------------------
// frame constants
// --------------------------------------------------------------------
`define EFM_PRE_OCT    8'h55
`define EFM_SFD_OCT    8'hd5
`define EFM_PRE_LAST   12'h007
`define EFM_HDR_LAST   12'h00d
`define EFM_MIN_DATA   11'h02e
`define EFM_PAD_LAST   12'h02d
`define EFM_FCS_LAST   12'h003
`define EFM_MAX_LEN    16'h05dc
`define EFM_CRC_POLY   32'hedb8_8320
`define EFM_CRC_INIT   32'hffff_ffff
`define EFM_CRC_RESID  32'hdebb_20e3
// --------------------------------------------------------------------
// timing
// --------------------------------------------------------------------
`define EFM_CLK_PERIOD_NS 4
`define EFM_NIB_PERIOD_NS 40
`endif

// ===== efm_pkg.sv
package efm_pkg;
  typedef enum logic [2:0] {
    TX_IDLE, TX_PRE, TX_BODY, TX_PAD, TX_FCS
  } efm_tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE, RX_SFD, RX_DATA, RX_TAIL, RX_HEAD, RX_DROP
  } efm_rx_state_t;
  typedef struct packed {
    logic duplex;
    logic crc_on;
    logic fill;
    logic tx_on;
  } efm_tx_ctl_t;
  typedef struct packed {
    logic       clk;
    logic       dv;
    logic [3:0] nib;
  } efm_phy_rx_t;
endpackage : efm_pkg

// ===== efm_crc_nib.sv
`timescale 1ns/1ns
`default_nettype none
`include "efm_defines.svh"
module efm_crc_nib (
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        init_i,
  input  wire logic        en_i,
  input  wire logic [3:0]  nib_i,
  output logic      [31:0] crc_o
);
  logic [31:0] next_crc;

  // reflected crc-32, one nibble lsb first per step
  always_comb begin
    next_crc = crc_o;
    for (int i = 0; i < 4; i++) begin
      if (next_crc[0] ^ nib_i[i])
        next_crc = (next_crc >> 1) ^ `EFM_CRC_POLY;
      else
        next_crc = next_crc >> 1;
    end
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (srst_i || init_i)
      crc_o <= `EFM_CRC_INIT;
    else if (en_i)
      crc_o <= next_crc;
  end
endmodule : efm_crc_nib
`default_nettype wire

// ===== efm_ram.sv
`timescale 1ns/1ns
`default_nettype none
module efm_ram #(
  parameter int AW = 9
) (
  input  wire logic          core_clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [31:0]   wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [31:0]   rdata_o
);
  logic [31:0] mem [2**AW];

  // one write port, asynchronous read port
  always_ff @(posedge core_clk_i) begin
    if (we_i)
      mem[waddr_i] <= wdata_i;
  end
  assign rdata_o = mem[raddr_i];
endmodule : efm_ram
`default_nettype wire

// ===== efm_phy_model.sv
`timescale 1ns/1ns
`default_nettype none
// loopback phy: keeps tx nibbles, replays them on rx
module efm_phy_model #(
  parameter int DIV = 8
) (
  input  wire logic       clk_i,
  input  wire logic       tx_en_i,
  input  wire logic [3:0] tx_nib_i,
  output logic            rx_clk_o,
  output logic            rx_dv_o,
  output logic [3:0]      rx_nib_o
);
  int         cnt;
  logic [3:0] cap[$];
  initial {cnt, rx_clk_o, rx_dv_o, rx_nib_o} = '0;
  // one nibble per DIV cycles, rx clock rises mid-nibble
  always @(posedge clk_i) begin
    cnt <= tx_en_i ? (cnt + 1) % DIV : 0;
    if (tx_en_i && cnt == 0) begin
      cap.push_back(tx_nib_i);
      rx_nib_o <= tx_nib_i;
    end
    if (!tx_en_i) rx_nib_o <= ~rx_nib_o; // released line toggles
    rx_dv_o  <= tx_en_i;
    rx_clk_o <= tx_en_i && cnt >= DIV / 2; // still between frames
  end
endmodule : efm_phy_model
`default_nettype wire

// ===== efm_mac_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module efm_mac_top_bench;
  logic clk = 0, srst = 1, rd = 0, wr = 0, transmit_on, rck, rdv, wt;
  logic [4:0]  adr = '0;
  logic [31:0] wd = '0, rdt, q;
  logic [3:0]  txn, rxn;
  int n_errors = 0, total_checks = 0, cyc = 0;
  efm_mac_top #(.NIB_DIV(8)) i_dut (.core_clk_i(clk), .srst_i(srst),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdt), .avs_waitrequest_o(wt),
    .phy_tx_nib_o(txn), .phy_tx_en_o(transmit_on), .phy_rx_clk_i(rck),
    .phy_rx_dv_i(rdv), .phy_rx_nib_i(rxn));
  efm_phy_model #(.DIV(8)) i_phy (.clk_i(clk), .tx_en_i(transmit_on),
    .tx_nib_i(txn), .rx_clk_o(rck), .rx_dv_o(rdv), .rx_nib_o(rxn));
  always #2 clk = ~clk;
  // watchdog
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    rd <= !w; wr <= w; adr <= a; wd <= d;
    do @(posedge clk); while (wt !== 1'b0);
    q = rdt;
    rd <= 0; wr <= 0;
    @(posedge clk);
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(q, e);
  endtask : rchk
  task report_and_stop;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // expected wire octet i of the first frame
  function automatic logic [7:0] oct(input int i);
    if (i < 6) return 8'(i + 1);
    if (i < 12) return 8'(i + 11);
    if (i == 13) return 8'h0a;
    if (i > 13 && i < 24) return 8'(i + 18);
    return 8'h00;
  endfunction : oct
  logic [31:0] fr[7] = '{32'h0201_000a, 32'h0605_0403, 32'h1413_1211,
    32'h0a00_1615, 32'h2322_2120, 32'h2726_2524, 32'h0000_2928};
  initial begin
    repeat (4) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    rchk(5'h00, 0);
    rchk(5'h1c, 0);
    bus(1, 5'h04, 32'h0000_0003);
    bus(1, 5'h00, 32'h0000_000f);
    for (int i = 0; i < 7; i++) bus(1, 5'h0c, fr[i]);
    bus(1, 5'h14, 1);
    do bus(0, 5'h08, 0); while (q[2] !== 1'b1);
    chk(i_phy.cap.size(), 144);
    for (int i = 0; i < 15; i++) chk(i_phy.cap[i], 5);
    chk(i_phy.cap[15], 4'hd);
    for (int i = 0; i < 60; i++) begin
      chk(i_phy.cap[16 + 2 * i], oct(i) & 8'h0f);
      chk(i_phy.cap[17 + 2 * i], oct(i) >> 4);
    end
    repeat (200) @(posedge clk);
    rchk(5'h08, 32'h0000_0006);
    rchk(5'h18, 32'h000a_0101);
    bus(0, 5'h10, 0);
    chk(q & 32'hffff_0fff, 32'h0201_0040);
    for (int i = 1; i < 4; i++) rchk(5'h10, fr[i]);
    rchk(5'h10, fr[4]);
    bus(1, 5'h08, 32'h0000_000f);
    bus(1, 5'h00, 32'h0000_000b);
    fr[0] = 32'h0201_0004;
    for (int i = 0; i < 6; i++) bus(1, 5'h0c, fr[i]);
    bus(1, 5'h14, 1);
    do bus(0, 5'h08, 0); while (q[2] !== 1'b1);
    repeat (200) @(posedge clk);
    rchk(5'h08, 32'h0000_000c);
    bus(1, 5'h04, 32'h0000_0002);
    bus(1, 5'h04, 32'h0000_0006);
    bus(0, 5'h18, 0);
    chk(q[5:0], 0);
    rchk(5'h10, 0);
    report_and_stop();
  end
endmodule : efm_mac_top_bench
`default_nettype wire
